// >>> design/cer_cable_reflectometry_ctrl.v
// What this block does
// - Enable bit hands both drivers over
// - Send bit fires pulse, starts monitor
// - Mode bit picks fast or slow driver
// - Width field 0..7 steps, zero no pulse
// - Bit 13 sends pulse on receive pair
// - Bit 7 selects minimum instead of maximum
// - Bit 12 monitors the receive pair
// - Window start and stop qualify samples
// - Window resets to start 0, stop 255
// - One window count per 8 ns
// - Peak at 18h, threshold at 19h
// - Fast pulses alternate polarity, 8 ns steps
// - Zero width still runs the monitor
// - Timer records first peak/crossing time
`timescale 1ns/1ns
`include "cer_regs.vh"

module cer_cable_reflectometry_ctrl #(
   parameter ADC_W = 8
) (
   input  wire              i_clk,
   input  wire              i_nrst,
   input  wire [4:0]        i_reg_addr,
   input  wire              i_reg_wr,
   input  wire [15:0]       i_reg_wdata,
   input  wire [ADC_W-1:0]  i_adc_tx_pair,
   input  wire [ADC_W-1:0]  i_adc_rx_pair,
   output reg  [15:0]       o_reg_rdata,
   output reg               o_normal_suspend,
   output reg               o_fast_line_driver_pulse,
   output reg               o_slow_line_driver_pulse,
   output reg               o_pulse_negative,
   output reg               o_pulse_on_rx_pair,
   output reg               o_busy
);

   // -----------------------------------------------
   // States
   // -----------------------------------------------
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN  = 2'b10;
   localparam [31:0] STEP_CNT  = `CER_STEP_CYCLES;
   localparam [1:0]  STEP_LAST = STEP_CNT[1:0] - 2'h1;

   reg  [15:0]      ctrl_q;
   reg  [15:0]      win_q;
   reg  [1:0]       state_q;
   reg  [1:0]       sub_q;
   reg  [7:0]       time_q;
   reg              pol_q;
   reg              pk_valid_q;
   reg  [ADC_W-1:0] pk_val_q;
   reg  [7:0]       pk_time_q;
   reg              thr_found_q;
   reg  [7:0]       thr_time_q;

   wire             enable   = ctrl_q[`CER_CTL_ENABLE];
   wire             min_mode = ctrl_q[`CER_CTL_MIN_MODE];
   wire [2:0]       width    = ctrl_q[`CER_CTL_WIDTH_HI:`CER_CTL_WIDTH_LO];
   wire [7:0]       win_start = win_q[`CER_WIN_START_HI:`CER_WIN_START_LO];
   wire [7:0]       win_stop  = win_q[`CER_WIN_STOP_HI:`CER_WIN_STOP_LO];
   wire             wr_ctrl  = i_reg_wr && (i_reg_addr == `CER_OFS_CONTROL);
   wire             wr_win   = i_reg_wr && (i_reg_addr == `CER_OFS_WINDOW);
   wire             start    = wr_ctrl && i_reg_wdata[`CER_CTL_ENABLE]
                               && i_reg_wdata[`CER_CTL_SEND] && (state_q == ST_IDLE);
   wire             tick     = (state_q == ST_RUN) && (sub_q == 2'h0);
   wire [ADC_W-1:0] sample   = ctrl_q[`CER_CTL_MON_RX] ? i_adc_rx_pair
                                                       : i_adc_tx_pair;
   wire             in_win   = (time_q >= win_start) && (time_q <= win_stop);
   wire             last     = (time_q == win_stop) || (time_q == `CER_LAST_STEP);
   wire [ADC_W-1:0] thr_mag  = {{(ADC_W-7){1'b0}},
                                ctrl_q[`CER_CTL_THR_HI:`CER_CTL_THR_LO]};
   wire [ADC_W-1:0] thr_neg  = ~thr_mag + {{(ADC_W-1){1'b0}}, 1'b1};
   // Pulse spans whole 8 ns steps; width zero never drives
   wire             pulse_on = (state_q == ST_RUN) && ({5'h00, width} > time_q);

   // Signed compare shared by peak and threshold tracking
   function sgt;
      input [ADC_W-1:0] a;
      input [ADC_W-1:0] b;
      begin
         sgt = $signed(a) > $signed(b);
      end
   endfunction

   wire pk_better = min_mode ? sgt(pk_val_q, sample) : sgt(sample, pk_val_q);
   wire thr_hit   = min_mode ? !sgt(sample, thr_neg) : !sgt(thr_mag, sample);

   // -----------------------------------------------
   // Registers and run sequencing
   // -----------------------------------------------
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_q      <= `CER_CONTROL_RST;
         win_q       <= `CER_WINDOW_RST;
         state_q     <= ST_IDLE;
         sub_q       <= 2'h0;
         time_q      <= 8'h00;
         pol_q       <= 1'b0;
         pk_valid_q  <= 1'b0;
         pk_val_q    <= {ADC_W{1'b0}};
         pk_time_q   <= 8'h00;
         thr_found_q <= 1'b0;
         thr_time_q  <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= i_reg_wdata;
            // Send bit stays set only while a run is in flight
            ctrl_q[`CER_CTL_SEND] <= start || (state_q == ST_RUN && i_reg_wdata[`CER_CTL_ENABLE]);
         end
         if (wr_win) begin
            win_q <= i_reg_wdata;
         end
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  state_q     <= ST_RUN;
                  // Step zero must last a full step, else the pulse loses a clock
                  sub_q       <= STEP_LAST;
                  time_q      <= 8'h00;
                  pk_valid_q  <= 1'b0;
                  pk_val_q    <= {ADC_W{1'b0}};
                  pk_time_q   <= 8'h00;
                  thr_found_q <= 1'b0;
                  thr_time_q  <= 8'h00;
                  if (i_reg_wdata[`CER_CTL_FAST_SEL] &&
                      i_reg_wdata[`CER_CTL_WIDTH_HI:`CER_CTL_WIDTH_LO] != 3'h0) begin
                     pol_q <= ~pol_q;
                  end
               end
            end
            ST_RUN: begin
               sub_q <= (sub_q == STEP_LAST) ? 2'h0 : sub_q + 2'h1;
               if (tick && in_win) begin
                  if (!pk_valid_q || pk_better) begin
                     pk_valid_q <= 1'b1;
                     pk_val_q   <= sample;
                     pk_time_q  <= time_q;
                  end
                  if (!thr_found_q && thr_hit) begin
                     thr_found_q <= 1'b1;
                     thr_time_q  <= time_q;
                  end
               end
               // Dropping enable aborts; partial results are kept
               if (!enable || (tick && last)) begin
                  state_q               <= ST_IDLE;
                  ctrl_q[`CER_CTL_SEND] <= 1'b0;
               end else if (tick) begin
                  time_q <= time_q + 8'h01;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------
   // Registered outputs
   // -----------------------------------------------
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_reg_rdata              <= 16'h0000;
         o_normal_suspend         <= 1'b0;
         o_fast_line_driver_pulse <= 1'b0;
         o_slow_line_driver_pulse <= 1'b0;
         o_pulse_negative         <= 1'b0;
         o_pulse_on_rx_pair       <= 1'b0;
         o_busy                   <= 1'b0;
      end else begin
         o_normal_suspend         <= enable;
         o_fast_line_driver_pulse <= pulse_on && ctrl_q[`CER_CTL_FAST_SEL];
         o_slow_line_driver_pulse <= pulse_on && !ctrl_q[`CER_CTL_FAST_SEL];
         o_pulse_negative         <= pol_q && ctrl_q[`CER_CTL_FAST_SEL];
         o_pulse_on_rx_pair       <= ctrl_q[`CER_CTL_TX_ON_RX];
         o_busy                   <= (state_q == ST_RUN);
         if (i_reg_addr == `CER_OFS_CONTROL) begin
            o_reg_rdata <= ctrl_q;
         end else if (i_reg_addr == `CER_OFS_WINDOW) begin
            o_reg_rdata <= win_q;
         end else if (i_reg_addr == `CER_OFS_PEAK) begin
            o_reg_rdata <= {pk_time_q, pk_val_q[7:0]};
         end else if (i_reg_addr == `CER_OFS_THRESHOLD) begin
            o_reg_rdata <= {thr_found_q, 7'h00, thr_time_q};
         end else begin
            o_reg_rdata <= 16'h0000;
         end
      end
   end

endmodule // cer_cable_reflectometry_ctrl

// >>> inc/cer_regs.vh
`ifndef CER_REGS_VH
`define CER_REGS_VH
// -----------------------------------------------
// Register offsets
// -----------------------------------------------
`define CER_OFS_CONTROL   5'h16
`define CER_OFS_WINDOW    5'h17
`define CER_OFS_PEAK      5'h18
`define CER_OFS_THRESHOLD 5'h19
// -----------------------------------------------
// Control field positions
// -----------------------------------------------
`define CER_CTL_ENABLE    15
`define CER_CTL_FAST_SEL  14
`define CER_CTL_TX_ON_RX  13
`define CER_CTL_MON_RX    12
`define CER_CTL_SEND      11
`define CER_CTL_WIDTH_HI  10
`define CER_CTL_WIDTH_LO  8
`define CER_CTL_MIN_MODE  7
`define CER_CTL_THR_HI    6
`define CER_CTL_THR_LO    0
// -----------------------------------------------
// Window fields and reset values
// -----------------------------------------------
`define CER_WIN_START_HI  15
`define CER_WIN_START_LO  8
`define CER_WIN_STOP_HI   7
`define CER_WIN_STOP_LO   0
`define CER_CONTROL_RST   16'h0000
`define CER_WINDOW_RST    16'h00FF
`define CER_THR_FOUND_BIT 15
// -----------------------------------------------
// Timing
// -----------------------------------------------
`define CER_CLK_PERIOD_NS 4
`define CER_STEP_NS       8
`define CER_STEP_CYCLES   (`CER_STEP_NS / `CER_CLK_PERIOD_NS)
`define CER_LAST_STEP     8'hFF
`endif

// >>> test/cer_cable_model.sv
`timescale 1ns/1ns
module cer_cable_model (
   input  wire logic       i_clk, i_busy, i_pulse, i_neg, i_on_rx,
   output logic      [7:0] o_tx, o_rx
);
   // ----
   // Echo on driven pair, crosstalk on other
   // ----
   int         cnt = 0;
   logic       hit = 0, sg = 0;
   logic [7:0] e, x;
   always @(posedge i_clk) begin
      cnt <= i_busy ? cnt + 1 : 0;
      if (i_pulse) {hit, sg} <= {1'b1, i_neg};
      else if (!i_busy) hit <= 0;
   end
   // Held 3 cycles so a one-cycle skew still lands in one step
   assign e = (hit && cnt > 7 && cnt < 11) ? (sg ? 8'hD8 : 8'h28) : 8'h02;
   assign x = (hit && cnt > 15 && cnt < 19) ? 8'hE2 : 8'h02;
   assign o_tx = i_on_rx ? x : e;
   assign o_rx = i_on_rx ? e : x;
endmodule // cer_cable_model

// >>> test/cer_cable_reflectometry_ctrl_bench.sv
`timescale 1ns/1ns
module cer_cable_reflectometry_ctrl_bench;
   // ----
   // Register tasks and run sequence
   // ----
   logic        i_clk = 0, i_nrst = 0, wr = 0;
   logic [4:0]  addr = 0;
   logic [15:0] wd = 0, rd;
   logic [7:0]  atx, arx;
   logic        sus, fp, sp, ng, orx, busy;
   int          n_fail = 0, n_compared = 0;
   initial forever #2 i_clk = ~i_clk;
   cer_cable_reflectometry_ctrl uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_wdata(wd), .i_adc_tx_pair(atx), .i_adc_rx_pair(arx),
      .o_reg_rdata(rd), .o_normal_suspend(sus), .o_fast_line_driver_pulse(fp),
      .o_slow_line_driver_pulse(sp), .o_pulse_negative(ng), .o_pulse_on_rx_pair(orx),
      .o_busy(busy));
   cer_cable_model cable (.i_clk(i_clk), .i_busy(busy), .i_pulse(fp | sp), .i_neg(ng),
      .i_on_rx(orx), .o_tx(atx), .o_rx(arx));
   task automatic cmp_bit(input logic v, e);
      n_compared++;
      if (v !== e) begin
         n_fail++;
         $display("CHECK FAILED %0t flag %b", $time, v);
      end
   endtask
   task automatic cmp_reg(input logic [4:0] a, input logic [15:0] e);
      @(posedge i_clk) addr <= a;
      @(posedge i_clk) #1 n_compared++;
      if (rd !== e) begin
         n_fail++;
         $display("CHECK FAILED %0t reg %h got %h", $time, a, rd);
      end
   endtask
   task automatic wreg(input logic [4:0] a, input logic [15:0] d);
      @(posedge i_clk) {addr, wd, wr} <= {a, d, 1'b1};
      @(posedge i_clk) wr <= 0;
   endtask
   // Whole window on all runs but the 06h-14h one, so those runs cost about 512 cycles
   task automatic run(input logic [15:0] c, pk, th);
      wreg(5'h16, c);
      repeat (2) @(posedge i_clk);
      #1 cmp_bit(busy, 1);
      cmp_bit(sus, 1);
      cmp_bit(orx, c[13]);
      for (int i = 0; i < 600 && busy === 1'b1; i++) #4;
      cmp_bit(busy, 0);
      cmp_reg(5'h18, pk);
      cmp_reg(5'h19, th);
   endtask
   task automatic summarize;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #40000;
      n_fail++;
      summarize;
   end
   initial begin
      repeat (2) @(posedge i_clk);
      i_nrst <= 1;
      cmp_reg(5'h16, 16'h0000);
      cmp_reg(5'h17, 16'h00FF);
      cmp_reg(5'h18, 16'h0000);
      cmp_reg(5'h1A, 16'h0000);
      run(16'h8B14, 16'h0428, 16'h8004);
      cmp_reg(5'h16, 16'h8314);
      wreg(5'h18, 16'hFFFF);
      cmp_reg(5'h18, 16'h0428);
      wreg(5'h17, 16'h0614);
      run(16'h8B14, 16'h0602, 16'h0000);
      wreg(5'h17, 16'h00FF);
      run(16'h9B94, 16'h08E2, 16'h8008);
      run(16'hF994, 16'h04D8, 16'h8004);
      run(16'hF914, 16'h0428, 16'h8004);
      run(16'h8814, 16'h0002, 16'h0000);
      // Enable dropped mid-run aborts; step 4 result must survive
      wreg(5'h16, 16'h8B14);
      repeat (8) @(posedge i_clk);
      wreg(5'h16, 16'h0314);
      repeat (2) @(posedge i_clk);
      #1 cmp_bit(busy, 0);
      cmp_bit(sus, 0);
      cmp_reg(5'h18, 16'h0428);
      cmp_reg(5'h16, 16'h0314);
      summarize;
   end
endmodule // cer_cable_reflectometry_ctrl_bench

// >>> test/cer_ctrl_props.sv
`timescale 1ns/1ns
module cer_ctrl_props (
   input wire logic        i_clk, i_nrst, i_reg_wr, o_busy, o_normal_suspend,
   input wire logic        o_pulse_on_rx_pair, o_fast_line_driver_pulse,
   input wire logic        o_slow_line_driver_pulse,
   input wire logic [4:0]  i_reg_addr,
   input wire logic [15:0] i_reg_wdata, o_reg_rdata
);
   // ----
   // Run capture and checks
   // ----
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   wire cw = i_reg_wr && i_reg_addr == 5'h16;
   wire st = cw && i_reg_wdata[15] && i_reg_wdata[11] && !o_busy;
   wire pl = o_fast_line_driver_pulse | o_slow_line_driver_pulse;
   logic [2:0] w_q;
   logic       m_q;
   logic [9:0] p_q;
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) {w_q, m_q, p_q} <= 14'h0000;
      else begin
         if (st) {w_q, m_q} <= {i_reg_wdata[10:8], i_reg_wdata[14]};
         p_q <= pl ? p_q + 10'h001 : 10'h000;
      end
   end
   a_suspend_tracks: assert property (cw |-> ##2 o_normal_suspend == $past(i_reg_wdata[15], 2))
      else $error("suspend wrong");
   a_rx_pair_tracks: assert property (cw |-> ##2 o_pulse_on_rx_pair == $past(i_reg_wdata[13], 2))
      else $error("pulse pair wrong");
   a_start_busy: assert property (st |-> ##2 o_busy)
      else $error("run not started");
   a_zero_width: assert property (st && i_reg_wdata[10:8] == 3'h0 |-> ##1 !pl [*8])
      else $error("pulse at zero width");
   a_pulse_width: assert property ($fell(pl) |-> p_q == {w_q, 1'b0})
      else $error("pulse width wrong");
   a_driver_select: assert property (pl |-> o_fast_line_driver_pulse == m_q)
      else $error("wrong driver");
   a_pulse_in_run: assert property (pl |-> o_busy)
      else $error("pulse outside run");
   a_unmapped_zero: assert property (i_reg_addr < 5'h16 || i_reg_addr > 5'h19 |=> o_reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   c_slow_run: cover property (st && !i_reg_wdata[14]);
   c_fast_run: cover property (st && i_reg_wdata[14]);
   c_zero_run: cover property (st && i_reg_wdata[10:8] == 3'h0);
endmodule // cer_ctrl_props
bind cer_cable_reflectometry_ctrl cer_ctrl_props u_props (
   .i_clk                    (i_clk),
   .i_nrst                   (i_nrst),
   .i_reg_wr                 (i_reg_wr),
   .o_busy                   (o_busy),
   .o_normal_suspend         (o_normal_suspend),
   .o_pulse_on_rx_pair       (o_pulse_on_rx_pair),
   .o_fast_line_driver_pulse (o_fast_line_driver_pulse),
   .o_slow_line_driver_pulse (o_slow_line_driver_pulse),
   .i_reg_addr               (i_reg_addr),
   .i_reg_wdata              (i_reg_wdata),
   .o_reg_rdata              (o_reg_rdata)
);
